// File: hw/cgc_clock_gating.v
// clock gating control registers with an axi4-lite slave
// Summary of operation
// (RULE_01) set port bit 0 starts processor clock
// (RULE_02) set port bit 7 starts usb clock
// (RULE_03) set port bits 8-10 start programmable outputs
// (RULE_04) clear port bit 0 stops processor clock
// (RULE_05) clear port bit 7 stops usb clock
// (RULE_06) clear port bits 8-10 stop programmable outputs
// (RULE_07) state bit 0 shows processor clock running
// (RULE_08) state bit 7 shows usb clock running
// (RULE_09) state bits 8-10 show programmable outputs
// (RULE_10) system state read-only, resets to 0x01
// (RULE_11) peripheral set bits 2-31 start clocks
// (RULE_12) peripheral clear bits 2-31 stop clocks
// (RULE_13) unimplemented peripheral bits change nothing
// (RULE_14) peripheral state read-only, resets to zero
// (RULE_15) system set and clear ports write-only
// (RULE_16) peripheral set and clear ports write-only
// (RULE_17) oscillator control read/write, resets zero
// (RULE_18) frequency register read-only, resets zero
// (RULE_19) master clock selection read/write, resets zero
// (RULE_20) programmable configs read/write, reset zero
// (RULE_21) interrupt ports write-only, mask read-only zero
// (RULE_22) peripheral state shows running clocks
// (RULE_23) software stops output before reconfiguring
// (RULE_24) set and clear share one state bit
// (RULE_25) reserved offsets read zero, ignore writes
//
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "cgc_consts.vh"

module cgc_clock_gating
(
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // axi4-lite write address
    input wire [7:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // axi4-lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // axi4-lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // axi4-lite read address
    input wire [7:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // axi4-lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // clock enables toward the gates
    output reg processor_clock_en,
    output reg usb_48mhz_clock_en,
    output reg [2:0] programmable_output_en,
    output reg [31:0] peripheral_clock_en,
    // configuration toward the clock generator
    output reg [31:0] main_oscillator_control,
    output reg [31:0] pll_configuration,
    output reg [31:0] master_clock_selection,
    output reg [31:0] programmable_clock_0_config,
    output reg [31:0] programmable_clock_1_config,
    output reg [31:0] interrupt_mask_state,
    // status from the clock generator (same clock domain)
    input wire [31:0] main_clock_frequency_in,
    input wire [31:0] unit_status_in
);

    // write channel capture: address and data may arrive in either order
    reg aw_held;
    reg w_held;
    reg [7:0] aw_addr;
    reg [31:0] w_data;
    reg [3:0] w_strb;
    reg [31:0] sys_state;
    reg [31:0] per_state;
    reg [31:0] main_freq;
    reg [31:0] unit_status;
    reg [31:0] next_rdata;
    reg next_rvalid_ok;
    wire do_write;
    wire [31:0] wmask;
    wire [31:0] sys_set;
    wire [31:0] sys_clr;
    wire [31:0] per_set;
    wire [31:0] per_clr;
    // reset pattern held as a word so each gate bit picks its own bit
    wire [31:0] sys_rst_val;
    genvar g;

    assign sys_rst_val = `CGC_RST_SYS_STATE;

    // byte strobes widen to a bit mask; partial writes touch only enabled lanes
    function [31:0] strb_mask;
        input [3:0] s;
        begin
            strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        end
    endfunction

    // merge a write into a read/write register under the lane mask
    function [31:0] merge;
        input [31:0] old;
        input [31:0] d;
        input [31:0] m;
        begin
            merge = (old & ~m) | (d & m);
        end
    endfunction

    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wmask = strb_mask(w_strb);

    assign sys_set = (do_write && aw_addr == `CGC_OFF_SYS_SET) ?
        (w_data & wmask & `CGC_SYS_MASK) : 32'h0000_0000; // see RULE_01, RULE_02, RULE_03
    assign sys_clr = (do_write && aw_addr == `CGC_OFF_SYS_CLR) ?
        (w_data & wmask & `CGC_SYS_MASK) : 32'h0000_0000; // see RULE_04, RULE_05, RULE_06
    // bits outside the implemented range are masked so they never reach state
    assign per_set = (do_write && aw_addr == `CGC_OFF_PER_SET) ?
        (w_data & wmask & `CGC_PER_MASK) : 32'h0000_0000; // see RULE_11, RULE_13
    assign per_clr = (do_write && aw_addr == `CGC_OFF_PER_CLR) ?
        (w_data & wmask & `CGC_PER_MASK) : 32'h0000_0000; // see RULE_12, RULE_13

    // handshake
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CGC_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !aw_held && !s_axi_awready && s_axi_awvalid;
            s_axi_wready <= !w_held && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held <= 1'b1;
                aw_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `CGC_RESP_OKAY;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_held <= 1'b0;
                w_held <= 1'b0;
            end
        end
    end

    // one shared bit per clock: a clear after a set wins, both in one write cannot occur
    generate
        for (g = 0; g < 32; g = g + 1)
        begin : gate_bits
            always @(posedge ref_clk)
            begin
                if (rst)
                begin
                    sys_state[g] <= sys_rst_val[g]; // see RULE_10
                    per_state[g] <= 1'b0; // see RULE_14
                end
                else
                begin
                    if (sys_set[g])
                        sys_state[g] <= 1'b1; // see RULE_24
                    else if (sys_clr[g])
                        sys_state[g] <= 1'b0; // see RULE_24
                    if (per_set[g])
                        per_state[g] <= 1'b1; // see RULE_24
                    else if (per_clr[g])
                        per_state[g] <= 1'b0; // see RULE_24
                end
            end
        end
    endgenerate

    // configuration registers and gate outputs
    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            main_oscillator_control <= `CGC_RST_ZERO;
            pll_configuration <= `CGC_RST_PLL_CFG;
            master_clock_selection <= `CGC_RST_ZERO;
            programmable_clock_0_config <= `CGC_RST_ZERO;
            programmable_clock_1_config <= `CGC_RST_ZERO;
            interrupt_mask_state <= `CGC_RST_ZERO; // see RULE_21
            main_freq <= `CGC_RST_ZERO; // see RULE_18
            unit_status <= `CGC_RST_UNIT_STATUS;
            processor_clock_en <= 1'b1;
            usb_48mhz_clock_en <= 1'b0;
            programmable_output_en <= 3'b000;
            peripheral_clock_en <= `CGC_RST_PER_STATE;
        end
        else
        begin
            main_freq <= main_clock_frequency_in;
            unit_status <= unit_status_in;
            // gate outputs follow state one cycle later, straight from flops
            processor_clock_en <= sys_state[`CGC_BIT_PROC];
            usb_48mhz_clock_en <= sys_state[`CGC_BIT_USB];
            programmable_output_en <= sys_state[`CGC_BIT_PROG0 +: `CGC_PROG_COUNT];
            peripheral_clock_en <= per_state;
            if (do_write)
            begin
                case (aw_addr)
                    `CGC_OFF_OSC_CTRL:
                        main_oscillator_control <= merge(main_oscillator_control, w_data, wmask); // see RULE_17
                    `CGC_OFF_PLL_CFG:
                        pll_configuration <= merge(pll_configuration, w_data, wmask);
                    `CGC_OFF_MCK_SEL:
                        master_clock_selection <= merge(master_clock_selection, w_data, wmask); // see RULE_19
                    // no interlock against an enabled output: software stops it first
                    `CGC_OFF_PROG0_CFG:
                        programmable_clock_0_config <= merge(programmable_clock_0_config, w_data, wmask); // see RULE_20
                    `CGC_OFF_PROG1_CFG:
                        programmable_clock_1_config <= merge(programmable_clock_1_config, w_data, wmask); // see RULE_20
                    `CGC_OFF_IRQ_SET:
                        interrupt_mask_state <= interrupt_mask_state | (w_data & wmask); // see RULE_21
                    `CGC_OFF_IRQ_CLR:
                        interrupt_mask_state <= interrupt_mask_state & ~(w_data & wmask); // see RULE_21
                    default:
                        interrupt_mask_state <= interrupt_mask_state; // see RULE_25
                endcase
            end
        end
    end

    // read decode: write-only ports and holes read zero with okay response
    always @*
    begin
        next_rvalid_ok = 1'b1;
        case ({s_axi_araddr[7:2], 2'b00})
            `CGC_OFF_SYS_STATE: next_rdata = sys_state & `CGC_SYS_MASK; // see RULE_07, RULE_08, RULE_09
            `CGC_OFF_PER_STATE: next_rdata = per_state & `CGC_PER_MASK; // see RULE_22
            `CGC_OFF_OSC_CTRL: next_rdata = main_oscillator_control;
            `CGC_OFF_MAIN_FREQ: next_rdata = main_freq; // see RULE_18
            `CGC_OFF_PLL_CFG: next_rdata = pll_configuration;
            `CGC_OFF_MCK_SEL: next_rdata = master_clock_selection;
            `CGC_OFF_PROG0_CFG: next_rdata = programmable_clock_0_config;
            `CGC_OFF_PROG1_CFG: next_rdata = programmable_clock_1_config;
            `CGC_OFF_UNIT_STATUS: next_rdata = unit_status;
            `CGC_OFF_IRQ_MASK: next_rdata = interrupt_mask_state;
            default: next_rdata = 32'h0000_0000; // see RULE_15, RULE_16, RULE_25
        endcase
    end

    always @(posedge ref_clk)
    begin
        if (rst)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CGC_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= next_rdata;
                s_axi_rresp <= next_rvalid_ok ? `CGC_RESP_OKAY : `CGC_RESP_SLVERR;
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// File: pkg/cgc_consts.vh
// register offsets, field positions and reset values for the clock gating control block
`ifndef CGC_CONSTS_VH
`define CGC_CONSTS_VH

`define CGC_OFF_SYS_SET 8'h00
`define CGC_OFF_SYS_CLR 8'h04
`define CGC_OFF_SYS_STATE 8'h08
`define CGC_OFF_PER_SET 8'h10
`define CGC_OFF_PER_CLR 8'h14
`define CGC_OFF_PER_STATE 8'h18
`define CGC_OFF_OSC_CTRL 8'h20
`define CGC_OFF_MAIN_FREQ 8'h24
`define CGC_OFF_PLL_CFG 8'h2C
`define CGC_OFF_MCK_SEL 8'h30
`define CGC_OFF_PROG0_CFG 8'h40
`define CGC_OFF_PROG1_CFG 8'h44
`define CGC_OFF_IRQ_SET 8'h60
`define CGC_OFF_IRQ_CLR 8'h64
`define CGC_OFF_UNIT_STATUS 8'h68
`define CGC_OFF_IRQ_MASK 8'h6C

`define CGC_BIT_PROC 0
`define CGC_BIT_USB 7
`define CGC_BIT_PROG0 8
`define CGC_PROG_COUNT 3
`define CGC_SYS_MASK 32'h0000_0781
`define CGC_PER_MASK 32'hFFFF_FFFC

`define CGC_RST_SYS_STATE 32'h0000_0001
`define CGC_RST_PER_STATE 32'h0000_0000
`define CGC_RST_ZERO 32'h0000_0000
`define CGC_RST_PLL_CFG 32'h0000_3F00
`define CGC_RST_UNIT_STATUS 32'h0000_0008

`define CGC_RESP_OKAY 2'b00
`define CGC_RESP_SLVERR 2'b10

`endif

// File: verification/cgc_gate_checker.sv
// concurrent checks on the clock gating control block ports
`timescale 1ns/1ns
module cgc_gate_checker
(
    // clock and reset
    input wire ref_clk,
    input wire rst,
    // bus handshakes
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire s_axi_rvalid,
    input wire s_axi_rready,
    // gate enables
    input wire processor_clock_en,
    input wire [31:0] peripheral_clock_en
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_taken |-> ##2 s_axi_bvalid) else $error("no write response");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid) else $error("no read data");
    a_bvalid_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("bvalid dropped");
    a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data moved");
    a_bresp_okay: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00) else $error("bad bresp");
    a_rresp_okay: assert property (s_axi_rvalid |-> s_axi_rresp == 2'b00) else $error("bad rresp");
    a_awready_pulse: assert property (s_axi_awready |=> !s_axi_awready) else $error("awready held");
    a_proc_reset_on: assert property ($fell(rst) |-> processor_clock_en) else $error("proc clock off at reset");
    a_per_reset_off: assert property ($fell(rst) |-> peripheral_clock_en == 32'h0000_0000)
        else $error("peripheral clock on at reset");
    a_per_low_bits: assert property (peripheral_clock_en[1:0] == 2'b00) else $error("low peripheral bits set");
endmodule
bind cgc_clock_gating cgc_gate_checker i_chk (.ref_clk(ref_clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .processor_clock_en(processor_clock_en), .peripheral_clock_en(peripheral_clock_en));

// File: verification/testbench.sv
// self-checking bench for the clock gating control block
`timescale 1ns/1ns
module testbench;
    reg ref_clk = 0, rst = 1;
    reg [7:0] awaddr = 0, araddr = 0;
    reg awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    reg [31:0] wdata = 0, freq_in = 0, stat_in = 0;
    reg [3:0] wstrb = 0;
    wire awready, wready, bvalid, arready, rvalid, proc_en, usb_en;
    wire [1:0] bresp, rresp;
    wire [2:0] prog_en;
    wire [31:0] rdata, per_en, osc, pll, mck, pc0, pc1, imr;
    integer bad_count = 0, checks = 0, seed = 21, i, k;
    logic [31:0] m [0:31];
    logic [31:0] got;
    logic [7:0] offs [0:13] = '{8'h00, 8'h04, 8'h10, 8'h14, 8'h20, 8'h2C, 8'h30, 8'h40, 8'h44, 8'h60, 8'h64,
        8'h0C, 8'h08, 8'h28};
    cgc_clock_gating i_dut (.ref_clk(ref_clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awprot(3'b000),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'b000), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .processor_clock_en(proc_en), .usb_48mhz_clock_en(usb_en),
        .programmable_output_en(prog_en), .peripheral_clock_en(per_en), .main_oscillator_control(osc),
        .pll_configuration(pll), .master_clock_selection(mck), .programmable_clock_0_config(pc0),
        .programmable_clock_1_config(pc1), .interrupt_mask_state(imr), .main_clock_frequency_in(freq_in),
        .unit_status_in(stat_in));
    initial forever #2 ref_clk = ~ref_clk;
    task chk(input [31:0] seen, input [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task conclude;
        if (bad_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // the bench waits on every answer; only the watchdog ends a hang
    task wr(input [7:0] a, input [31:0] d, input [3:0] s);
        @(posedge ref_clk);
        awaddr <= a; awvalid <= 1; wdata <= d; wstrb <= s; wvalid <= 1; bready <= 1;
        forever
        begin
            @(posedge ref_clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) break;
        end
        bready <= 0;
    endtask
    task rd(input [7:0] a);
        @(posedge ref_clk);
        araddr <= a; arvalid <= 1; rready <= 1;
        forever
        begin
            @(posedge ref_clk);
            if (arready) arvalid <= 0;
            if (rvalid) break;
        end
        got = rdata;
        rready <= 0;
    endtask
    // model: strobes mask bytes, set/clear share one state word per group
    task mdl_wr(input [7:0] a, input [31:0] d, input [3:0] s);
        logic [31:0] bm, v;
        bm = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        v = d & bm;
        case (a)
            8'h00: m[2] = m[2] | (v & 32'h0000_0781);
            8'h04: m[2] = m[2] & ~(v & 32'h0000_0781);
            8'h10: m[6] = m[6] | (v & 32'hFFFF_FFFC);
            8'h14: m[6] = m[6] & ~(v & 32'hFFFF_FFFC);
            8'h20, 8'h2C, 8'h30, 8'h40, 8'h44: m[a >> 2] = (m[a >> 2] & ~bm) | v;
            8'h60: m[27] = m[27] | v;
            8'h64: m[27] = m[27] & ~v;
            default: ;
        endcase
    endtask
    task mdl_reset;
        for (k = 0; k < 32; k++) m[k] = 32'h0000_0000;
        m[2] = 32'h0000_0001;
        m[11] = 32'h0000_3F00;
        m[9] = freq_in;
        m[26] = stat_in;
    endtask
    task chk_outs;
        chk({proc_en, usb_en, prog_en}, {m[2][0], m[2][7], m[2][10:8]});
        chk(per_en, m[6]);
        chk(osc ^ mck ^ pc0 ^ pc1, m[8] ^ m[12] ^ m[16] ^ m[17]);
        chk(pll, m[11]);
        chk(imr, m[27]);
    endtask
    task read_all;
        for (i = 0; i < 32; i++)
        begin
            rd(i * 4);
            chk(got, m[i]);
        end
        chk_outs;
    endtask
    initial
    begin
        #100000;
        bad_count++;
        conclude;
    end
    initial
    begin
        freq_in <= $random(seed);
        stat_in <= $random(seed);
        repeat (8) @(posedge ref_clk);
        rst <= 0;
        mdl_reset;
        read_all;
        wr(8'h00, 32'hFFFF_FFFF, 4'hF); mdl_wr(8'h00, 32'hFFFF_FFFF, 4'hF);
        wr(8'h10, 32'hFFFF_FFFF, 4'hF); mdl_wr(8'h10, 32'hFFFF_FFFF, 4'hF);
        @(posedge ref_clk);
        read_all;
        // reconfigure output 0 the legal way: stop it, change it, start it again
        wr(8'h04, 32'h0000_0100, 4'hF); mdl_wr(8'h04, 32'h0000_0100, 4'hF);
        wr(8'h40, 32'h0000_0015, 4'hF); mdl_wr(8'h40, 32'h0000_0015, 4'hF);
        wr(8'h00, 32'h0000_0100, 4'hF); mdl_wr(8'h00, 32'h0000_0100, 4'hF);
        @(posedge ref_clk);
        read_all;
        for (i = 0; i < 120; i++)
        begin
            awaddr <= awaddr;
            k = $unsigned($random(seed)) % 14;
            got = $random(seed);
            wr(offs[k], got, $random(seed));
            mdl_wr(offs[k], got, wstrb);
            rd(8'h08);
            chk(got, m[2]);
            rd(8'h18);
            chk(got, m[6]);
            rd(offs[k]);
            chk(got, m[offs[k] >> 2]);
            chk_outs;
        end
        @(posedge ref_clk);
        rst <= 1;
        repeat (2) @(posedge ref_clk);
        rst <= 0;
        mdl_reset;
        read_all;
        conclude;
    end
endmodule
